//--- design/rf_request_state_filter.sv
`timescale 1ns/100ps
`default_nettype none
//Behaviour
//(R1) Tag transmits only after a whole request was received and checked.
//(R2) Reader sends flags, command, parameters, data, two-byte check, between delimiters.
//(R3) Response is flags, parameters, data, two-byte check; no command code.
//(R4) Frames carry whole bytes; a partial byte drops the frame.
//(R5) Bits least significant first; multi-byte fields low byte first.
//(R6) Optional field present exactly when its flag is one.
//(R7) Tag has four states: unpowered, ready, quiet, selected.
//(R8) Unpowered without enough energy; ready once energy is present; code also waits for field_on before leaving unpowered.
//(R9) Ready tag answers requests without select flag, ignores select requests; code sends the 03h error to those with address flag set.
//(R10) Quiet tag ignores inventory requests having the address flag set.
//(R11) Selected tag answers select, matching addressed and general requests.
//(R12) General requests answered in ready or selected; quiet stays silent.
//(R13) Address flag set: compare carried 64-bit identifier, answer on equality.
//(R14) Addressed request with foreign identifier gets no response; with select flag also set, the code sends the 03h error anyway.
//(R15) Address flag clear: no identifier field; answer subject to state.
//(R16) Select flag set: no identifier; only selected tag answers; with address flag too, ready and quiet tags send the 03h error.
//(R17) Field absent for the field-off interval returns tag to unpowered.
//(R18) Reader keeps at most one tag selected at a time.
//(R19) Both address and select flags set: error response with code 03h.
//(R20) Inventory flag clear: bit 5 select, bit 6 address flag.
//(R21) Check register preset to all ones before first byte.
//(R22) Request with bad check is dropped silently.
//(R23) Response flag bit 1 set on error, then an error code follows.
module rf_request_state_filter #(
   parameter int unsigned FIELD_ABSENT_CYCLES = rf_filter_pkg::FIELD_ABSENT_CYCLES
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   input  wire logic [7:0]              paddr,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    energy_ok,
   input  wire logic                    field_on,
   input  wire logic                    rx_valid,
   input  wire rf_filter_pkg::rx_byte_s rx,
   input  wire rf_filter_pkg::state_cmd_s state_cmd,
   output logic                         req_valid,
   output rf_filter_pkg::req_s          req,
   output logic                         tx_valid,
   output logic [7:0]                   tx_data,
   output logic                         tx_last,
   input  wire logic                    tx_ready,
   output rf_filter_pkg::tag_state_e    tag_state
);
   import rf_filter_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic [31:0] ctrl;
   logic [31:0] uid_lo;
   logic [31:0] uid_hi;
   logic [15:0] last_req;
   logic [7:0]  drop_cnt;
   logic        in_frame;
   logic        done_q;
   logic        frame_err;
   logic [4:0]  nbytes;
   logic [7:0]  flags_q;
   logic [7:0]  cmd_q;
   logic [63:0] uid_rx;
   logic [15:0] crc;
   logic [31:0] absent_cnt;
   logic        absent_hit;
   logic        tx_busy;
   logic [1:0]  tx_idx;
   logic [15:0] tx_crc;
   logic [2:0]  uid_pos;
   logic        inv;
   logic        sel;
   logic        adr;
   logic        uid_match;
   logic        crc_ok;
   logic        len_ok;
   logic        frame_ok;
   logic        answer;
   logic        err_opt;
   logic        tx_hs;
   logic [15:0] next_tx_crc;
   logic        apb_wr;
   logic        apb_rd;

   // Register bus: zero wait states
   assign pready = 1'b1;
   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & ~penable & ~pwrite;
   assign pslverr = psel & penable & ~(paddr == ADDR_CTRL || paddr == ADDR_UID_LO ||
                    paddr == ADDR_UID_HI || paddr == ADDR_STATUS || paddr == ADDR_LAST);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl   <= CTRL_RESET;
         uid_lo <= UID_RESET;
         uid_hi <= UID_RESET;
      end else if (apb_wr) begin
         case (paddr)
            ADDR_CTRL:   ctrl <= pwdata & CTRL_RESET;
            ADDR_UID_LO: uid_lo <= pwdata;
            ADDR_UID_HI: uid_hi <= pwdata;
            default:     ;
         endcase
      end
   end

   // Read data is staged in the setup cycle so it leaves a flip-flop
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (apb_rd) begin
         case (paddr)
            ADDR_CTRL:   prdata <= ctrl;
            ADDR_UID_LO: prdata <= uid_lo;
            ADDR_UID_HI: prdata <= uid_hi;
            ADDR_STATUS: prdata <= {16'h0000, drop_cnt, 4'h0, in_frame, tx_busy, tag_state};
            ADDR_LAST:   prdata <= {16'h0000, last_req};
            default:     prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Field-off timer; saturates so a long absence cannot wrap
   assign absent_hit = (absent_cnt == 32'(FIELD_ABSENT_CYCLES - 1));
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) absent_cnt <= 32'h0000_0000;
      else if (field_on) absent_cnt <= 32'h0000_0000;
      else if (!absent_hit) absent_cnt <= absent_cnt + 32'h0000_0001;
   end

   // Tag state machine [R7]
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tag_state <= ST_OFF;
      end else if (!energy_ok || (absent_hit && !field_on)) begin
         tag_state <= ST_OFF; // [R8] [R17]
      end else begin
         case (tag_state)
            ST_OFF:  if (field_on) tag_state <= ST_READY; // [R8]
            default: begin
               if (state_cmd.go_select) tag_state <= ST_SELECTED;
               else if (state_cmd.go_quiet) tag_state <= ST_QUIET;
               else if (state_cmd.go_ready) tag_state <= ST_READY;
               else if (state_cmd.deselect && tag_state == ST_SELECTED) tag_state <= ST_READY;
            end
         endcase
      end
   end

   // Request capture: byte 0 flags, byte 1 command [R2]
   assign uid_pos = 3'(nbytes - 5'h02);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         in_frame  <= 1'b0;
         done_q    <= 1'b0;
         frame_err <= 1'b0;
         nbytes    <= 5'h00;
         flags_q   <= 8'h00;
         cmd_q     <= 8'h00;
         uid_rx    <= 64'h0000_0000_0000_0000;
         crc       <= CRC_PRESET;
      end else begin
         done_q <= 1'b0;
         if (rx_valid && rx.sof) begin
            in_frame  <= ~rx.eof;
            done_q    <= rx.eof;
            frame_err <= rx.partial; // [R4]
            nbytes    <= 5'h01;
            flags_q   <= rx.data;
            crc       <= crc16_byte(CRC_PRESET, rx.data); // [R21]
         end else if (rx_valid && in_frame) begin
            in_frame  <= ~rx.eof;
            done_q    <= rx.eof;
            frame_err <= frame_err | rx.partial; // [R4]
            if (nbytes != 5'h1F) nbytes <= nbytes + 5'h01;
            crc <= crc16_byte(crc, rx.data);
            if (nbytes == 5'h01) cmd_q <= rx.data;
            // Identifier only when addressed, low byte first [R6] [R5]
            if (adr && nbytes >= 5'h02 && nbytes <= 5'h09) uid_rx[{uid_pos, 3'b000} +: 8] <= rx.data;
         end
      end
   end

   // Flag decode [R20]
   assign inv = flags_q[FLAG_INVENTORY];
   assign sel = ~inv & flags_q[FLAG_SELECT];
   assign adr = ~inv & flags_q[FLAG_ADDRESS];
   assign uid_match = (uid_rx == {uid_hi, uid_lo}); // [R13]
   assign crc_ok = (crc == CRC_RESIDUE);
   assign len_ok = (nbytes >= (adr ? MIN_ADDR_BYTES : MIN_REQ_BYTES));
   assign err_opt = sel & adr; // [R19]
   // Bad check, partial byte or short frame: no reply at all [R22]
   assign frame_ok = done_q & ctrl[CTRL_ENABLE_BIT] & ~frame_err & crc_ok & len_ok & ~tx_busy &
                     (tag_state != ST_OFF);

   always_comb begin
      answer = 1'b0;
      case (tag_state)
         ST_READY:    answer = ~sel & (~adr | uid_match); // [R9] [R12] [R14] [R15]
         ST_QUIET:    answer = inv ? ~flags_q[FLAG_ADDRESS] : (adr & uid_match); // [R10] [R12]
         ST_SELECTED: answer = ~adr | uid_match; // [R11] [R16]
         default:     answer = 1'b0;
      endcase
   end

   // Hand-off of an accepted request to command execution
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         req_valid <= 1'b0;
         req       <= '0;
         last_req  <= 16'h0000;
         drop_cnt  <= 8'h00;
      end else begin
         req_valid <= frame_ok & ~err_opt & answer; // [R1] [R13]
         if (frame_ok && !err_opt && answer) begin
            req      <= '{flags: flags_q, cmd: cmd_q, addressed: adr};
            last_req <= {cmd_q, flags_q};
         end
         if (done_q && !(crc_ok && !frame_err) && drop_cnt != 8'hFF) drop_cnt <= drop_cnt + 8'h01;
      end
   end

   // Error response: flags, code, check low, check high; no command field [R3] [R23]
   assign tx_valid = tx_busy;
   assign tx_last = tx_busy & (tx_idx == 2'h3);
   assign tx_hs = tx_busy & tx_ready;
   assign next_tx_crc = crc16_byte(tx_crc, tx_data);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_busy <= 1'b0;
         tx_idx  <= 2'h0;
         tx_data <= 8'h00;
         tx_crc  <= CRC_PRESET;
      end else if (frame_ok && err_opt) begin
         tx_busy <= 1'b1; // [R1] [R19]
         tx_idx  <= 2'h0;
         tx_data <= RESP_FLAGS_ERROR; // [R23]
         tx_crc  <= CRC_PRESET; // [R21]
      end else if (tx_hs) begin
         tx_idx <= tx_idx + 2'h1;
         case (tx_idx)
            2'h0: begin
               tx_data <= ERR_OPTION;
               tx_crc  <= next_tx_crc;
            end
            2'h1: begin
               tx_data <= ~next_tx_crc[7:0]; // [R5]
               tx_crc  <= next_tx_crc;
            end
            2'h2:    tx_data <= ~tx_crc[15:8];
            default: tx_busy <= 1'b0;
         endcase
      end
   end

   a_tx_after_req: assert property ($rose(tx_valid) |-> $past(done_q) && $past(crc_ok)) // [R1]
      else $error("response started without a checked request");
   a_off_silent: assert property (req_valid |-> $past(tag_state) != ST_OFF) // [R8]
      else $error("request passed while unpowered");
   a_ready_nosel: assert property (req_valid && $past(tag_state) == ST_READY |-> // [R9]
      !(req.flags[FLAG_SELECT] && !req.flags[FLAG_INVENTORY]))
      else $error("ready tag passed a select request");
   a_quiet_inv: assert property (req_valid && $past(tag_state) == ST_QUIET && // [R10]
      req.flags[FLAG_INVENTORY] |-> !req.flags[FLAG_ADDRESS])
      else $error("quiet tag passed inventory with address flag");
   a_quiet_general: assert property (req_valid && $past(tag_state) == ST_QUIET && // [R12]
      !req.flags[FLAG_INVENTORY] |-> req.addressed)
      else $error("quiet tag passed a general request");
   a_uid_match: assert property (req_valid && req.addressed |-> $past(uid_match)) // [R14]
      else $error("addressed request passed with foreign identifier");
   a_crc_drop: assert property (req_valid |-> $past(crc_ok) && !$past(frame_err)) // [R22]
      else $error("request passed with bad check or partial byte");
   a_err_code: assert property ($rose(tx_valid) |-> tx_data == RESP_FLAGS_ERROR && tx_idx == 2'h0 // [R19]
      ##1 (tx_data == RESP_FLAGS_ERROR || tx_data == ERR_OPTION))
      else $error("error response does not open with flags and code");
   a_err_len: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid) // [R3]
      else $error("error response runs past its last byte");
   a_err_end: assert property ($fell(tx_valid) |-> $past(tx_last) && $past(tx_ready)) // [R3]
      else $error("error response ended before its last byte");
   a_field_off: assert property (absent_hit && !field_on |=> tag_state == ST_OFF) // [R17]
      else $error("tag stayed powered after field-off interval");
   a_power_up: assert property (tag_state == ST_OFF && energy_ok && field_on |=> tag_state == ST_READY) // [R8]
      else $error("powered tag did not become ready");
   a_select_only: assert property (req_valid && req.flags[FLAG_SELECT] && !req.flags[FLAG_INVENTORY] |-> // [R16]
      $past(tag_state) == ST_SELECTED)
      else $error("select request passed outside selected state");
   a_drop_silent: assert property (done_q && !crc_ok |=> !req_valid && !$rose(tx_valid)) // [R22]
      else $error("frame with bad check was answered");
   a_partial_drop: assert property (done_q && frame_err |=> !req_valid && !$rose(tx_valid)) // [R4]
      else $error("frame with partial byte was answered");

   c_addressed: cover property (req_valid && req.addressed);
   c_error_resp: cover property ($rose(tx_valid) ##[1:20] tx_last && tx_ready);
   c_selected: cover property (tag_state == ST_SELECTED && req_valid);
   c_drop: cover property (done_q && !crc_ok);
   c_quiet_inventory: cover property (req_valid && tag_state == ST_QUIET && req.flags[FLAG_INVENTORY]);
endmodule : rf_request_state_filter
`default_nettype wire

//--- design/rf_filter_pkg.sv
`default_nettype none
package rf_filter_pkg;
   // Register map, one aligned 32-bit word each
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_UID_LO     = 8'h04;
   localparam logic [7:0]  ADDR_UID_HI     = 8'h08;
   localparam logic [7:0]  ADDR_STATUS     = 8'h0C;
   localparam logic [7:0]  ADDR_LAST       = 8'h10;
   localparam int          CTRL_ENABLE_BIT = 0;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
   localparam logic [31:0] UID_RESET       = 32'h0000_0000;
   // Request flag positions (flag bit n sits at index n-1)
   localparam int          FLAG_INVENTORY  = 2;
   localparam int          FLAG_SELECT     = 4;
   localparam int          FLAG_ADDRESS    = 5;
   // Response fields
   localparam logic [7:0]  RESP_FLAGS_ERROR = 8'h01;
   localparam logic [7:0]  ERR_OPTION       = 8'h03;
   // Frame check
   localparam logic [15:0] CRC_PRESET  = 16'hFFFF;
   localparam logic [15:0] CRC_POLY    = 16'h8408;
   localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;
   localparam logic [4:0]  MIN_REQ_BYTES  = 5'h04;
   localparam logic [4:0]  MIN_ADDR_BYTES = 5'h0C;
   // Timing
   localparam int CLK_HZ          = 40_000_000;
   localparam int FIELD_ABSENT_US = 1000;
   localparam int FIELD_ABSENT_CYCLES = (FIELD_ABSENT_US * (CLK_HZ / 1_000_000));

   typedef enum logic [1:0] {
      ST_OFF      = 2'b00,
      ST_READY    = 2'b01,
      ST_QUIET    = 2'b10,
      ST_SELECTED = 2'b11
   } tag_state_e;

   typedef struct packed {
      logic       sof;
      logic       eof;
      logic       partial;
      logic [7:0] data;
   } rx_byte_s;

   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] cmd;
      logic       addressed;
   } req_s;

   typedef struct packed {
      logic go_ready;
      logic go_quiet;
      logic go_select;
      logic deselect;
   } state_cmd_s;

   function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] d);
      logic [15:0] c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         if (c[0] ^ d[i]) c = (c >> 1) ^ CRC_POLY;
         else c = c >> 1;
      end
      return c;
   endfunction : crc16_byte
endpackage : rf_filter_pkg
`default_nettype wire

//--- bench/reader_model.sv
`timescale 1ns/100ps
`default_nettype none
module reader_model (
   input  wire logic               clk_sys,
   output logic                    rx_valid,
   output rf_filter_pkg::rx_byte_s rx,
   output logic                    tx_ready
);
   import rf_filter_pkg::*;
   initial begin
      rx_valid = 1'b0;
      rx = '0;
      tx_ready = 1'b0;
   end
   // Random stalls on the response side, as a slow transmitter would give
   always @(posedge clk_sys) begin
      tx_ready <= 1'($urandom_range(0, 1));
   end
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
      return c;
   endfunction : crc_step
   task automatic send(input logic [7:0] f, input logic [7:0] c, input logic [63:0] u, input logic bad,
                       input logic part);
      logic [7:0]  q[$];
      logic [15:0] crc;
      q = {f, c};
      if (f[FLAG_ADDRESS] && !f[FLAG_INVENTORY]) begin
         for (int i = 0; i < 8; i++) q.push_back(u[8*i +: 8]);
      end
      crc = 16'hFFFF;
      foreach (q[i]) crc = crc_step(crc, q[i]);
      crc = ~crc ^ 16'(bad);
      q.push_back(crc[7:0]);
      q.push_back(crc[15:8]);
      foreach (q[i]) begin
         @(posedge clk_sys);
         rx_valid <= 1'b1;
         rx <= '{sof: i == 0, eof: i == q.size() - 1, partial: part && i == q.size() - 1, data: q[i]};
         repeat ($urandom_range(0, 1)) begin
            @(posedge clk_sys);
            rx_valid <= 1'b0;
         end
      end
      @(posedge clk_sys);
      rx_valid <= 1'b0;
   endtask : send
endmodule : reader_model
`default_nettype wire

//--- bench/test_rf_request_state_filter.sv
`timescale 1ns/100ps
`default_nettype none
module test_rf_request_state_filter;
   import rf_filter_pkg::*;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, energy_ok, field_on;
   logic rx_valid, req_valid, tx_valid, tx_last, tx_ready;
   logic [7:0]  paddr, tx_data;
   logic [31:0] pwdata, prdata, q;
   logic [63:0] uid;
   logic        e;
   rx_byte_s    rx;
   state_cmd_s  state_cmd;
   req_s        req;
   tag_state_e  tag_state;
   logic [17:0] notes[$];
   int          n_errors, tests_run;
   rf_request_state_filter #(.FIELD_ABSENT_CYCLES(16)) i_rf_request_state_filter (.clk_sys, .rst, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .energy_ok, .field_on, .rx_valid, .rx, .state_cmd,
      .req_valid, .req, .tx_valid, .tx_data, .tx_last, .tx_ready, .tag_state);
   reader_model i_reader_model (.clk_sys, .rx_valid, .rx, .tx_ready);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         $display("wrong value %s expected %h seen %h", nm, x, g);
         n_errors++;
      end
   endtask : chk
   // Every output event must match the oldest note; an event with no note is a spurious answer
   task automatic got(input logic [17:0] v);
      chk("output event", (notes.size() > 0) ? notes.pop_front() : 18'h3FFFF, v);
   endtask : got
   always @(posedge clk_sys) begin
      if (rst === 1'b0 && req_valid === 1'b1) got({1'b0, req});
      if (rst === 1'b0 && tx_valid === 1'b1 && tx_ready === 1'b1) got({10'h200 | tx_last, tx_data});
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 1, pready);
      if (pready !== 1'b1) print_verdict();
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk("read data", x, q);
      chk("pslverr", xe, e);
   endtask : rd
   task automatic frame(input logic [7:0] f, input logic [63:0] u, input logic bad, input logic part,
                        input logic ans);
      logic [7:0]  c;
      logic [15:0] k;
      c = 8'($urandom);
      k = ~i_reader_model.crc_step(i_reader_model.crc_step(16'hFFFF, RESP_FLAGS_ERROR), ERR_OPTION);
      if (ans && f[FLAG_SELECT] && f[FLAG_ADDRESS]) begin
         notes.push_back({10'h200, RESP_FLAGS_ERROR});
         notes.push_back({10'h200, ERR_OPTION});
         notes.push_back({10'h200, k[7:0]});
         notes.push_back({10'h201, k[15:8]});
      end else if (ans) begin
         notes.push_back({1'b0, f, c, f[FLAG_ADDRESS] & ~f[FLAG_INVENTORY]});
      end
      i_reader_model.send(f, c, u, bad, part);
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < 64 && tx_valid !== 1'b0; i++) @(posedge clk_sys);
      @(posedge clk_sys);
      chk("tx idle", 0, tx_valid);
      if (tx_valid !== 1'b0) print_verdict();
      chk("pending notes", 0, notes.size());
   endtask : frame
   task automatic scmd(input logic [3:0] c, input tag_state_e s);
      @(posedge clk_sys);
      state_cmd <= state_cmd_s'(c);
      @(posedge clk_sys);
      state_cmd <= '0;
      repeat (2) @(posedge clk_sys);
      chk("tag_state", s, tag_state);
   endtask : scmd
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      state_cmd = '0;
      energy_ok = 1'b1;
      field_on = 1'b1;
      n_errors = 0;
      tests_run = 0;
      void'($urandom(53786));
      uid = {$urandom, $urandom};
      repeat (2) @(posedge clk_sys);
      chk("tag_state", ST_OFF, tag_state);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("tag_state", ST_READY, tag_state);
      rd(ADDR_CTRL, CTRL_RESET, 1'b0);
      rd(ADDR_UID_HI, UID_RESET, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      apb(1'b1, ADDR_UID_LO, uid[31:0]);
      apb(1'b1, ADDR_UID_HI, uid[63:32]);
      rd(ADDR_UID_LO, uid[31:0], 1'b0);
      $display("test registers done");
      frame(8'h02, uid, 1'b0, 1'b0, 1'b1);
      frame(8'h12, uid, 1'b0, 1'b0, 1'b0);
      frame(8'h22, uid, 1'b0, 1'b0, 1'b1);
      frame(8'h22, uid ^ (64'h1 << 60), 1'b0, 1'b0, 1'b0);
      frame(8'h02, uid, 1'b1, 1'b0, 1'b0);
      frame(8'h02, uid, 1'b0, 1'b1, 1'b0);
      frame(8'h32, uid, 1'b0, 1'b0, 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h0);
      frame(8'h02, uid, 1'b0, 1'b0, 1'b0);
      apb(1'b1, ADDR_CTRL, CTRL_RESET);
      $display("test ready done");
      scmd(4'b0100, ST_QUIET);
      frame(8'h02, uid, 1'b0, 1'b0, 1'b0);
      frame(8'h22, uid, 1'b0, 1'b0, 1'b1);
      frame(8'h26, uid, 1'b0, 1'b0, 1'b0);
      frame(8'h06, uid, 1'b0, 1'b0, 1'b1);
      $display("test quiet done");
      scmd(4'b0010, ST_SELECTED);
      rd(ADDR_STATUS, {16'h0000, 8'h02, 6'h00, ST_SELECTED}, 1'b0);
      frame(8'h12, uid, 1'b0, 1'b0, 1'b1);
      frame(8'h02, uid, 1'b0, 1'b0, 1'b1);
      frame(8'h22, uid, 1'b0, 1'b0, 1'b1);
      frame(8'h22, ~uid, 1'b0, 1'b0, 1'b0);
      scmd(4'b0001, ST_READY);
      scmd(4'b0100, ST_QUIET);
      scmd(4'b0001, ST_QUIET);
      scmd(4'b1000, ST_READY);
      $display("test selected done");
      field_on <= 1'b0;
      repeat (12) @(posedge clk_sys);
      chk("tag_state", ST_READY, tag_state);
      for (int i = 0; i < 20 && tag_state !== ST_OFF; i++) @(posedge clk_sys);
      chk("tag_state", ST_OFF, tag_state);
      field_on <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("tag_state", ST_READY, tag_state);
      energy_ok <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("tag_state", ST_OFF, tag_state);
      frame(8'h02, uid, 1'b0, 1'b0, 1'b0);
      $display("test power done");
      print_verdict();
   end
endmodule : test_rf_request_state_filter
`default_nettype wire
